//--- logic/rsm_top.sv
`timescale 1ns/1ps
`include "rsm_map.svh"

// Function
// - carrier sense lost ends receive at once while no sync found
// - on timeout keep receive if sync/quality met
// - three-bit timeout code, 111 disables timeout
// - timeout scales with wake period and coefficient
// - clear-channel result follows selected policy
// - clear-channel result driven on output pin
// - after receive go to selected state
// - after send go to selected state
// - stay-in-transmit restarts preamble immediately
module rsm_top import rsm_pkg::*; #(
    parameter int REF_MHZ = `RSM_REF_MHZ,
    parameter int EVENT_W = 16
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [`RSM_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // radio command strobes
    input wire logic cmd_rx,
    input wire logic cmd_tx,
    input wire logic cmd_idle,
    // modem status, same clock
    input wire logic carrier_sense,
    input wire logic pqt_reached,
    input wire logic sync_found,
    input wire logic rx_packet_done,
    input wire logic tx_packet_done,
    // wake timer settings
    input wire logic [EVENT_W-1:0] wake_event_period,
    input wire logic [1:0] wake_period_resolution,
    // status outputs
    output logic [1:0] radio_state,
    output logic in_packet,
    output logic channel_clear,
    output logic rx_timeout,
    output logic preamble_restart
);

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ****************************************
    // state
    // ****************************************
    localparam rsm_top_st_t ST_RESET = '{
        rx_stop: `RSM_RXSTOP_RESET,
        keep_qual: `RSM_KEEP_RESET,
        limit: `RSM_LIMIT_RESET,
        cca_pol: rsm_cca_t'(`RSM_CCA_RESET),
        after_rx: rsm_after_rx_t'(`RSM_AFTER_RX_RESET),
        after_tx: rsm_after_tx_t'(`RSM_AFTER_TX_RESET),
        ack: 1'b0,
        rdata: 32'h0,
        radio: RSM_IDLE,
        in_packet: 1'b0,
        cca: 1'b0,
        timeout: 1'b0,
        preamble: 1'b0
    };

    rsm_top_st_t st_reg;
    rsm_top_st_t st_next;
    logic bus_req;
    logic hit_to;
    logic hit_ns;
    logic [31:0] rd_mux;
    logic keep;
    logic rssi_drop;
    logic timer_expired;
    logic timer_restart;
    logic timer_run;

    // ****************************************
    // receive timeout timer
    // ****************************************
    // restart on every fresh search so stay-in-receive rearms the timeout
    assign timer_restart = (st_reg.radio != RSM_RX) | rx_packet_done;
    assign timer_run = (st_reg.radio == RSM_RX) & ~st_reg.in_packet;

    rsm_rx_timer #(
        .REF_MHZ(REF_MHZ),
        .EVENT_W(EVENT_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .restart(timer_restart),
        .run(timer_run),
        .limit_code(st_reg.limit),
        .resolution(wake_period_resolution),
        .event_period(wake_event_period),
        .expired(timer_expired)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.timeout = 1'b0;
        st_next.preamble = 1'b0;
        bus_req = avs_read | avs_write;
        hit_to = avs_address == `RSM_ADDR_RX_TIMEOUT;
        hit_ns = avs_address == `RSM_ADDR_NEXT_STATE;

        // readback: upper bits stay zero
        rd_mux = 32'h0;
        if (hit_to) begin
            rd_mux[`RSM_RXSTOP_BIT] = st_reg.rx_stop;
            rd_mux[`RSM_KEEP_BIT] = st_reg.keep_qual;
            rd_mux[`RSM_LIMIT_LSB +: 3] = st_reg.limit;
        end else if (hit_ns) begin
            rd_mux[`RSM_CCA_LSB +: 2] = st_reg.cca_pol;
            rd_mux[`RSM_AFTER_RX_LSB +: 2] = st_reg.after_rx;
            rd_mux[`RSM_AFTER_TX_LSB +: 2] = st_reg.after_tx;
        end

        // one wait state: read data sampled in the first cycle, write data stored and answer given in the second
        if (bus_req && !st_reg.ack) begin
            st_next.ack = 1'b1;
            st_next.rdata = rd_mux;
        end else if (st_reg.ack) begin
            st_next.ack = 1'b0;
            if (avs_write && avs_byteenable[0]) begin
                // only defined fields are stored
                if (hit_to) begin
                    st_next.rx_stop = avs_writedata[`RSM_RXSTOP_BIT];
                    st_next.keep_qual = avs_writedata[`RSM_KEEP_BIT];
                    st_next.limit = avs_writedata[`RSM_LIMIT_LSB +: 3];
                end else if (hit_ns) begin
                    st_next.cca_pol = rsm_cca_t'(avs_writedata[`RSM_CCA_LSB +: 2]);
                    st_next.after_rx = rsm_after_rx_t'(avs_writedata[`RSM_AFTER_RX_LSB +: 2]);
                    st_next.after_tx = rsm_after_tx_t'(avs_writedata[`RSM_AFTER_TX_LSB +: 2]);
                end
            end
        end

        // radio control
        keep = st_reg.in_packet | sync_found | (st_reg.keep_qual & pqt_reached);
        rssi_drop = st_reg.rx_stop & ~carrier_sense & ~st_reg.in_packet & ~sync_found;
        if (cmd_idle) begin
            st_next.radio = RSM_IDLE;
        end else begin
            unique case (st_reg.radio)
                RSM_IDLE, RSM_FSTX: begin
                    if (cmd_tx) begin
                        st_next.radio = RSM_TX;
                    end else if (cmd_rx) begin
                        st_next.radio = RSM_RX;
                    end
                end
                RSM_RX: begin
                    if (sync_found) begin
                        st_next.in_packet = 1'b1;
                    end
                    if (rx_packet_done && st_reg.in_packet) begin
                        st_next.in_packet = 1'b0;
                        // tx choices assume software left clear-channel unused
                        unique case (st_reg.after_rx)
                            RSM_ARX_IDLE: st_next.radio = RSM_IDLE;
                            RSM_ARX_FSTX: st_next.radio = RSM_FSTX;
                            RSM_ARX_TX: st_next.radio = RSM_TX;
                            RSM_ARX_RX: st_next.radio = RSM_RX;
                        endcase
                    end else if (cmd_tx && !st_reg.in_packet) begin
                        st_next.radio = RSM_TX;
                    end else if (rssi_drop) begin
                        st_next.radio = RSM_IDLE;
                    end else if (timer_expired) begin
                        st_next.timeout = 1'b1;
                        if (!keep) begin
                            st_next.radio = RSM_IDLE;
                        end
                    end
                end
                RSM_TX: begin
                    if (tx_packet_done) begin
                        unique case (st_reg.after_tx)
                            RSM_ATX_IDLE: st_next.radio = RSM_IDLE;
                            RSM_ATX_FSTX: st_next.radio = RSM_FSTX;
                            RSM_ATX_TX: st_next.preamble = 1'b1;
                            RSM_ATX_RX: st_next.radio = RSM_RX;
                        endcase
                    end
                end
            endcase
        end
        if (st_next.radio != RSM_RX) begin
            st_next.in_packet = 1'b0;
        end

        // clear channel assessment
        unique case (st_reg.cca_pol)
            RSM_CCA_ALWAYS: st_next.cca = 1'b1;
            RSM_CCA_QUIET: st_next.cca = ~carrier_sense;
            RSM_CCA_NO_PKT: st_next.cca = ~st_reg.in_packet;
            RSM_CCA_BOTH: st_next.cca = ~carrier_sense & ~st_reg.in_packet;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_RESET;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // a frozen block must not complete a bus cycle it cannot record
    assign avs_waitrequest = bus_req & (~st_reg.ack | ~ce);
    assign avs_readdata = st_reg.rdata;
    assign radio_state = st_reg.radio;
    assign in_packet = st_reg.in_packet;
    assign channel_clear = st_reg.cca;
    assign rx_timeout = st_reg.timeout;
    assign preamble_restart = st_reg.preamble;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_ns_write;
        avs_write && !avs_waitrequest && hit_ns && avs_byteenable[0];
    endsequence

    sequence s_ns_readback;
        avs_read && !avs_waitrequest && hit_ns;
    endsequence

    chk_rssi_stop_exit: assert property (
        ce && !cmd_idle && st_reg.radio == RSM_RX && !(rx_packet_done && st_reg.in_packet)
        && !(cmd_tx && !st_reg.in_packet) && rssi_drop |=> radio_state == RSM_IDLE)
        else $error("carrier loss did not end receive");

    chk_timeout_keep: assert property (
        ce && !cmd_idle && st_reg.radio == RSM_RX && !rx_packet_done && !cmd_tx
        && !rssi_drop && timer_expired && keep |=> radio_state == RSM_RX && rx_timeout)
        else $error("receive left although keep condition held");

    chk_timeout_leave: assert property (
        ce && !cmd_idle && st_reg.radio == RSM_RX && !rx_packet_done && !cmd_tx
        && !rssi_drop && timer_expired && !keep |=> radio_state == RSM_IDLE)
        else $error("receive kept after timeout without sync");

    chk_cca_policy: assert property (
        ce |=> channel_clear == ($past(st_reg.cca_pol) == RSM_CCA_ALWAYS
        || ($past(st_reg.cca_pol) == RSM_CCA_QUIET && !$past(carrier_sense))
        || ($past(st_reg.cca_pol) == RSM_CCA_NO_PKT && !$past(st_reg.in_packet))
        || ($past(st_reg.cca_pol) == RSM_CCA_BOTH && !$past(carrier_sense)
        && !$past(st_reg.in_packet))))
        else $error("clear channel output wrong for policy");

    chk_after_rx_state: assert property (
        ce && !cmd_idle && st_reg.radio == RSM_RX && st_reg.in_packet && rx_packet_done
        |=> radio_state == (($past(st_reg.after_rx) == RSM_ARX_IDLE) ? RSM_IDLE :
        ($past(st_reg.after_rx) == RSM_ARX_FSTX) ? RSM_FSTX :
        ($past(st_reg.after_rx) == RSM_ARX_TX) ? RSM_TX : RSM_RX))
        else $error("wrong state after packet received");

    chk_after_tx_state: assert property (
        ce && !cmd_idle && st_reg.radio == RSM_TX && tx_packet_done
        |=> radio_state == (($past(st_reg.after_tx) == RSM_ATX_IDLE) ? RSM_IDLE :
        ($past(st_reg.after_tx) == RSM_ATX_FSTX) ? RSM_FSTX :
        ($past(st_reg.after_tx) == RSM_ATX_TX) ? RSM_TX : RSM_RX))
        else $error("wrong state after packet sent");

    chk_preamble_again: assert property (
        ce && !cmd_idle && st_reg.radio == RSM_TX && tx_packet_done
        && st_reg.after_tx == RSM_ATX_TX |=> preamble_restart && radio_state == RSM_TX)
        else $error("preamble not restarted in stay-in-transmit");

    chk_ns_write_masked: assert property (
        s_ns_write ##0 ce |=> st_reg.cca_pol == $past(avs_writedata[`RSM_CCA_LSB +: 2])
        && st_reg.after_tx == $past(avs_writedata[`RSM_AFTER_TX_LSB +: 2]))
        else $error("next-state register write not stored");

    chk_readback_zero: assert property (
        s_ns_readback |-> avs_readdata[31:6] == 26'h0)
        else $error("unused register bits not zero");

    chk_bus_answer: assert property (
        bus_req && !st_reg.ack && ce ##1 bus_req && ce |-> !avs_waitrequest)
        else $error("bus answer later than one wait state");

endmodule : rsm_top

//--- logic/rsm_map.svh
`ifndef RSM_MAP_SVH
`define RSM_MAP_SVH

// ****************************************
// register indices and byte addresses
// ****************************************
`define RSM_ADDR_W 18
`define RSM_IDX_RX_TIMEOUT 16'hdf12
`define RSM_IDX_NEXT_STATE 16'hdf13
`define RSM_ADDR_RX_TIMEOUT {`RSM_IDX_RX_TIMEOUT, 2'b00}
`define RSM_ADDR_NEXT_STATE {`RSM_IDX_NEXT_STATE, 2'b00}

// ****************************************
// field positions
// ****************************************
`define RSM_RXSTOP_BIT 4
`define RSM_KEEP_BIT 3
`define RSM_LIMIT_LSB 0
`define RSM_CCA_LSB 4
`define RSM_AFTER_RX_LSB 2
`define RSM_AFTER_TX_LSB 0

// ****************************************
// reset values
// ****************************************
`define RSM_RXSTOP_RESET 1'b0
`define RSM_KEEP_RESET 1'b0
`define RSM_LIMIT_RESET 3'h7
`define RSM_CCA_RESET 2'h3
`define RSM_AFTER_RX_RESET 2'h0
`define RSM_AFTER_TX_RESET 2'h0

// ****************************************
// timeout arithmetic
// ****************************************
`define RSM_LIMIT_OFF 3'h7
`define RSM_SYS_MHZ 25
`define RSM_REF_MHZ 26
`define RSM_COEF_REF_MHZ 26
`define RSM_COEF_DEN 208
`define RSM_COEF_NUM0 14'h02ee
`define RSM_COEF_NUM1 14'h0ea6
`define RSM_COEF_NUM2 14'h1a5e
`define RSM_COEF_NUM3 14'h2616
`define RSM_ACC_W 40

`endif

//--- logic/rsm_pkg.sv
`include "rsm_map.svh"

package rsm_pkg;

    typedef enum logic [1:0] {
        RSM_IDLE = 2'h0,
        RSM_RX = 2'h1,
        RSM_TX = 2'h3,
        RSM_FSTX = 2'h2
    } rsm_radio_t;

    typedef enum logic [1:0] {
        RSM_CCA_ALWAYS = 2'h0,
        RSM_CCA_QUIET = 2'h1,
        RSM_CCA_NO_PKT = 2'h2,
        RSM_CCA_BOTH = 2'h3
    } rsm_cca_t;

    typedef enum logic [1:0] {
        RSM_ARX_IDLE = 2'h0,
        RSM_ARX_FSTX = 2'h1,
        RSM_ARX_TX = 2'h2,
        RSM_ARX_RX = 2'h3
    } rsm_after_rx_t;

    typedef enum logic [1:0] {
        RSM_ATX_IDLE = 2'h0,
        RSM_ATX_FSTX = 2'h1,
        RSM_ATX_TX = 2'h2,
        RSM_ATX_RX = 2'h3
    } rsm_after_tx_t;

    typedef struct packed {
        logic [`RSM_ACC_W-1:0] acc;
        logic done;
        logic expired;
    } rsm_timer_st_t;

    typedef struct packed {
        logic rx_stop;
        logic keep_qual;
        logic [2:0] limit;
        rsm_cca_t cca_pol;
        rsm_after_rx_t after_rx;
        rsm_after_tx_t after_tx;
        logic ack;
        logic [31:0] rdata;
        rsm_radio_t radio;
        logic in_packet;
        logic cca;
        logic timeout;
        logic preamble;
    } rsm_top_st_t;

endpackage : rsm_pkg

//--- logic/rsm_rx_timer.sv
`timescale 1ns/1ps
`include "rsm_map.svh"

module rsm_rx_timer import rsm_pkg::*; #(
    parameter int REF_MHZ = `RSM_REF_MHZ,
    parameter int EVENT_W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // control
    input wire logic restart,
    input wire logic run,
    input wire logic [2:0] limit_code,
    input wire logic [1:0] resolution,
    input wire logic [EVENT_W-1:0] event_period,
    // result
    output logic expired
);

    rsm_timer_st_t st_reg;
    rsm_timer_st_t st_next;
    logic [`RSM_ACC_W-1:0] coef;
    logic [`RSM_ACC_W-1:0] step;
    logic [`RSM_ACC_W-1:0] target;
    logic [`RSM_ACC_W-1:0] sum;

    // ****************************************
    // exact compare: cycles * den * ref << code >= period * num * 26 * sys
    // ****************************************
    always_comb begin
        unique case (resolution)
            2'h0: coef = `RSM_ACC_W'(`RSM_COEF_NUM0);
            2'h1: coef = `RSM_ACC_W'(`RSM_COEF_NUM1);
            2'h2: coef = `RSM_ACC_W'(`RSM_COEF_NUM2);
            2'h3: coef = `RSM_ACC_W'(`RSM_COEF_NUM3);
        endcase
        step = `RSM_ACC_W'(`RSM_COEF_DEN * REF_MHZ) << limit_code;
        target = `RSM_ACC_W'(event_period) * coef
            * `RSM_ACC_W'(`RSM_COEF_REF_MHZ * `RSM_SYS_MHZ);
        sum = st_reg.acc + step;
        st_next = st_reg;
        st_next.expired = 1'b0;
        if (restart) begin
            st_next.acc = '0;
            st_next.done = 1'b0;
        end else if (run && !st_reg.done && limit_code != `RSM_LIMIT_OFF) begin
            if (sum >= target) begin
                st_next.expired = 1'b1;
                st_next.done = 1'b1;
            end else begin
                st_next.acc = sum;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign expired = st_reg.expired;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_timer_off_silent: assert property (
        limit_code == `RSM_LIMIT_OFF && !restart && ce |=> !expired)
        else $error("timeout fired with timeout disabled");

    chk_timer_reach_fires: assert property (
        ce && !restart && run && !st_reg.done && limit_code != `RSM_LIMIT_OFF
        && sum >= target |=> expired)
        else $error("timeout missed when count reached");

    chk_timer_not_early: assert property (
        ce && !restart && sum < target |=> !expired)
        else $error("timeout fired early");

endmodule : rsm_rx_timer

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "rsm_map.svh"

`define RSM_CHECK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

module tb_top import rsm_pkg::*;;
    typedef struct {
        logic [31:0] v;
        logic [31:0] m;
    } rsm_exp_t;

    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic [`RSM_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [5:0] strb = '0;
    logic carrier_sense = 1'b1;
    logic pqt_reached = 1'b0;
    logic [15:0] wake_event_period = 16'h0008;
    logic [1:0] wake_period_resolution = 2'h0;
    logic [1:0] radio_state;
    logic in_packet;
    logic channel_clear;
    logic rx_timeout;
    logic preamble_restart;
    logic probe = 1'b0;
    int miscompares = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'h50;
    rsm_exp_t expq[$];
    rsm_exp_t e;
    logic [31:0] obs;
    int t_code[6] = '{6, 5, 6, 6, 6, 7};
    int t_res[6] = '{2, 1, 0, 3, 0, 0};
    int t_keep[6] = '{0, 0, 1, 0, 0, 0};
    int t_pqt[6] = '{0, 0, 1, 1, 0, 0};
    int t_sync[6] = '{0, 0, 0, 0, 1, 0};
    int t_stay[6] = '{0, 0, 1, 0, 1, 1};
    logic [1:0] nxt[4] = '{2'h0, 2'h2, 2'h3, 2'h1};

    always #20 clk_sys = ~clk_sys;

    rsm_top u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cmd_rx(strb[0]), .cmd_tx(strb[1]), .cmd_idle(strb[2]),
        .carrier_sense(carrier_sense), .pqt_reached(pqt_reached),
        .sync_found(strb[3]), .rx_packet_done(strb[4]), .tx_packet_done(strb[5]),
        .wake_event_period(wake_event_period),
        .wake_period_resolution(wake_period_resolution),
        .radio_state(radio_state), .in_packet(in_packet),
        .channel_clear(channel_clear), .rx_timeout(rx_timeout),
        .preamble_restart(preamble_restart)
    );

    // ****************************************
    // monitor: oldest note against each result
    // ****************************************
    always @(posedge clk_sys) begin
        if ((avs_read && !avs_waitrequest) || probe) begin
            obs = probe ? {26'h0, radio_state, in_packet, channel_clear, rx_timeout,
                preamble_restart} : avs_readdata;
            if (expq.size() == 0) begin
                miscompares++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, obs, 32'h0);
            end else begin
                e = expq.pop_front();
                `RSM_CHECK(obs & e.m, e.v & e.m)
            end
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // rounded up: a timeout never ends before its nominal time
    function automatic int ncyc(input int code, input int res);
        real c[4] = '{3.6058, 18.0288, 32.4519, 46.8750};
        return int'($ceil(16.0 * c[res] * 26.0 / 26.0 / real'(1 << code) * 25.0 / 2.0));
    endfunction : ncyc

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d,
            input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] be);
        bus(1'b1, a, d, be);
    endtask : wr

    task automatic rd(input logic [17:0] a, input logic [31:0] x);
        expq.push_back('{x, 32'hffffffff});
        bus(1'b0, a, 32'h0, 4'hf);
    endtask : rd

    // more: a further probe follows at once, so probe stays up
    task automatic st(input logic [5:0] v, input logic [5:0] m, input bit more = 1'b0);
        expq.push_back('{{26'h0, v}, {26'h0, m}});
        probe <= 1'b1;
        @(posedge clk_sys);
        if (!more) probe <= 1'b0;
    endtask : st

    // only this strobe drops, so a following pulse may raise another bit
    task automatic pulse(input int i);
        strb[i] <= 1'b1;
        @(posedge clk_sys);
        strb[i] <= 1'b0;
    endtask : pulse

    task automatic end_test(input string name);
        $display("test %s done at %0t", name, $time);
    endtask : end_test

    task automatic conclude();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // ****************************************
    // watchdog
    // ****************************************
    initial begin
        #(40 * 20000);
        miscompares++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        conclude();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] r;
        logic [31:0] r2;
        int n;
        int hit;
        cyc(3);
        resetn <= 1'b1;
        cyc(3);
        rd(`RSM_ADDR_RX_TIMEOUT, 32'h07);
        rd(`RSM_ADDR_NEXT_STATE, 32'h30);
        rd(18'h00010, 32'h0);
        ce <= 1'b0;
        fork
            rd(`RSM_ADDR_RX_TIMEOUT, 32'h07);
            begin cyc(4); ce <= 1'b1; end
        join
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            r2 = rnd();
            wr(`RSM_ADDR_RX_TIMEOUT, r, 4'h1);
            rd(`RSM_ADDR_RX_TIMEOUT, r & 32'h1f);
            wr(`RSM_ADDR_NEXT_STATE, r2, 4'hf);
            rd(`RSM_ADDR_NEXT_STATE, r2 & 32'h3f);
        end
        wr(`RSM_ADDR_RX_TIMEOUT, ~r, 4'h0);
        rd(`RSM_ADDR_RX_TIMEOUT, r & 32'h1f);
        end_test("registers");
        // idle, so no policy sees a packet and only the carrier can change the result
        pulse(2);
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 2; c++) begin
                wr(`RSM_ADDR_NEXT_STATE, 32'(m << 4), 4'h1);
                carrier_sense <= c[0];
                cyc(2);
                st({3'h0, (m[0] ? !c[0] : 1'b1), 2'b00}, 6'h3f);
            end
        end
        carrier_sense <= 1'b1;
        end_test("clear channel");
        wr(`RSM_ADDR_RX_TIMEOUT, 32'h07, 4'h1);
        // policy only used with idle or stay-in-rx, never with tx next
        for (int a = 0; a < 4; a++) begin
            n = (a == 0 || a == 3) ? 2 : 0;
            wr(`RSM_ADDR_NEXT_STATE, 32'((n << 4) | (a << 2)), 4'h1);
            pulse(2);
            pulse(0);
            st(6'b01_0000, 6'h38);
            pulse(3);
            cyc(2);
            st({3'b011, (n == 2) ? 1'b0 : 1'b1, 2'b00}, 6'h3c);
            pulse(4);
            st({nxt[a], 4'h0}, 6'h38);
        end
        end_test("after receive");
        for (int t = 0; t < 4; t++) begin
            wr(`RSM_ADDR_NEXT_STATE, 32'(t), 4'h1);
            pulse(2);
            pulse(1);
            st(6'b11_0000, 6'h39);
            pulse(5);
            st({nxt[t], 3'b000, (t == 2) ? 1'b1 : 1'b0}, 6'h39, 1'b1);
            st({nxt[t], 4'h0}, 6'h31);
        end
        end_test("after send");
        for (int i = 0; i < 6; i++) begin
            wr(`RSM_ADDR_RX_TIMEOUT, 32'((t_keep[i] << 3) | t_code[i]), 4'h1);
            wake_period_resolution <= 2'(t_res[i]);
            pqt_reached <= t_pqt[i][0];
            n = (t_code[i] == 7) ? 40 : ncyc(t_code[i], t_res[i]);
            pulse(2);
            pulse(0);
            if (t_sync[i] != 0) pulse(3);
            hit = 0;
            for (int k = 1; k <= n + 6; k++) begin
                @(posedge clk_sys);
                if (rx_timeout === 1'b1 && hit == 0) hit = k;
            end
            st(t_stay[i] != 0 ? 6'b01_0000 : 6'h00, 6'h30);
            if (t_stay[i] == 0) `RSM_CHECK(32'(hit >= n && hit <= n + 3), 32'h1)
            if (t_code[i] == 7) `RSM_CHECK(hit, 0)
            pqt_reached <= 1'b0;
        end
        end_test("rx timeout");
        for (int s = 0; s < 2; s++) begin
            wr(`RSM_ADDR_RX_TIMEOUT, 32'((s << 4) | 7), 4'h1);
            pulse(2);
            pulse(0);
            cyc(2);
            carrier_sense <= 1'b0;
            cyc(3);
            st(s != 0 ? 6'h00 : 6'b01_0000, 6'h30);
            carrier_sense <= 1'b1;
        end
        end_test("carrier stop");
        cyc(3);
        conclude();
    end
endmodule : tb_top
